// ---- rtl/cmp_mode_ctrl.sv ----
// mode and low-power controller sitting between the cpu register port and the
// can protocol engine: listen-only, loopback, disable, sleep, power down, init.
// assumes the protocol engine reports activity and bit ticks on the same clock.
//
// Overview of operation
// RL1: listen-only receives, drives recessive, never transmits
// RL2: listen-only loops own dominant bits to monitor
// RL3: loopback feeds tx to rx, pin recessive
// RL4: loopback ignores acknowledge slot, raises both interrupts
// RL5: module disabled stops all controller clocks
// RL6: wake interrupt needs sleep, wakeup and irq enables
// RL7: wait with stop_in_wait powers down, then restarts
// RL8: deep stop powers down; light stop follows sleep
// RL9: sleep waits until all tx buffers empty
// RL10: sleep waits for bus idle, then sync delay
// RL11: sleep acknowledge set once sleep active
// RL12: sleep stops core clocks, keeps registers, tx recessive
// RL13: sleep blocks foreground moves and aborts
// RL14: without wakeup enable, receive line held recessive
// RL15: leave sleep on activity or cleared request
// RL16: after wake wait 11 recessive bits
// RL17: on wake release all deferred actions
// RL18: init aborts traffic, tx pin recessive at once
// RL19: init stops controller, resets registers, unlocks config
// RL20: init request synchronised, then acknowledge set
// RL21: init request cannot clear before acknowledge
// RL22: clearing init request returns to normal
`timescale 1ns/100ps
`default_nettype none
module cmp_mode_ctrl
  import cmp_pkg::*;
(
  input wire logic clock, // 50 MHz bus clock
  input wire logic reset, // asynchronous, active high
  input wire logic [1:0] regAddr, // register offset
  input wire logic [7:0] regWrData, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [7:0] regRdData, // read data, cycle after strobe
  input wire logic cpuWait, // cpu in wait mode
  input wire logic cpuStopLight, // cpu in light stop mode
  input wire logic cpuStopDeep, // cpu in deepest stop modes
  input wire logic busRxPin, // bus_rx_pin, 0 is dominant
  output logic busTxPin, // bus_tx_pin, 1 is recessive
  input wire logic macTxBit, // bit the protocol engine wants to send
  output logic macRxBit, // receive line seen by the protocol engine
  input wire logic bitTick, // one pulse per bus bit time
  input wire logic txActive, // engine transmitting
  input wire logic rxActive, // engine receiving
  input wire logic [2:0] txBufEmptyFlag, // tx_buffer_empty_flag per buffer
  output logic txStartAllow, // engine may start a new frame
  output logic ignoreAckSlot, // treat missing acknowledge as fine
  output logic selfRxAllow, // own frame counts as received, both irqs
  output logic coreClkEn, // protocol engine clock enable
  output logic regClkEn, // register access clock enable
  output logic fgMoveAllow, // rx_background_buffer to foreground allowed
  output logic abortAllow, // transmit aborts may be carried out
  output logic busOffCountEn, // bus-off recovery counting allowed
  output logic engineAbort, // abort frame and drop bus sync
  output logic initRegReset, // hold engine registers at defaults
  output logic configUnlock, // bit timing and filters writable
  output logic wakeRelease, // one-cycle pulse: run deferred actions
  output logic wakeupIrq // wake-up interrupt request, level
);

  // all state in one record
  typedef struct packed {
    cmp_state_t state; // operating state
    logic init_request; // init_request
    logic sleep_request; // sleep_request
    logic wakeup_enable; // wakeup_enable
    logic stop_in_wait; // stop_in_wait
    logic enable; // module_enable
    logic enWritten; // enable is write-once
    logic listen; // listen-only selected
    logic loopback; // loopback self test selected
    logic wakeup_irq_enable; // wakeup_irq_enable
    logic wakeFlag; // sticky wake-up event
    logic wupeHeld; // wakeup enable as seen at sleep entry
    logic [3:0] cnt; // sync delay counter
    logic [3:0] recCnt; // consecutive recessive bits
    logic wakePulse; // deferred actions release
    logic [7:0] rdData; // registered read data
  } cmp_regs_t;

  cmp_regs_t cur_ff; // registered state
  cmp_regs_t nxt_cur; // next state
  logic powerDown; // power down demanded by cpu mode
  logic sleepAck; // sleep_acknowledge
  logic initAck; // init_acknowledge
  logic txAllEmpty; // nothing scheduled

  // bit placement in an 8-bit register image
  function automatic logic [7:0] cmp_bit(input logic val, input int pos);
    cmp_bit = 8'h00;
    cmp_bit[pos[2:0]] = val;
  endfunction : cmp_bit

  // decodes for the next-state logic; initAck also drives the outputs
  always_comb
  begin
    sleepAck = (cur_ff.state == ST_SLEEP); // RL11
    initAck = (cur_ff.state == ST_INIT); // RL20
    txAllEmpty = &txBufEmptyFlag;
    // light stop keeps sleep when it was set beforehand; deep stop always powers down
    powerDown = cur_ff.enable &
                (cpuStopDeep | // RL8
                 (cpuStopLight & !sleepAck) | // RL8
                 (cpuWait & !cpuStopLight & !cpuStopDeep & cur_ff.stop_in_wait)); // RL7
  end

  // next-state: register writes first, then the mode sequencer may override
  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.wakePulse = 1'h0;
    nxt_cur.rdData = 8'h00;
    // register reads, answered one cycle later
    if (regRd)
    begin
      unique case (regAddr)
        CTRL0_OFS: nxt_cur.rdData = cmp_bit(cur_ff.init_request, INIT_REQUEST_BIT) |
                                     cmp_bit(cur_ff.sleep_request, SLEEP_REQUEST_BIT) |
                                     cmp_bit(cur_ff.wakeup_enable, WAKEUP_ENABLE_BIT) |
                                     cmp_bit(cur_ff.stop_in_wait, STOP_IN_WAIT_BIT);
        CTRL1_OFS: nxt_cur.rdData = cmp_bit(initAck, INIT_ACKNOWLEDGE_BIT) |
                                     cmp_bit(sleepAck, SLEEP_ACKNOWLEDGE_BIT) |
                                     cmp_bit(cur_ff.listen, LISTEN_BIT) |
                                     cmp_bit(cur_ff.loopback, LOOP_BIT) |
                                     cmp_bit(cur_ff.enable, ENABLE_BIT);
        RIER_OFS: nxt_cur.rdData = cmp_bit(cur_ff.wakeup_irq_enable, WAKE_BIT);
        RFLG_OFS: nxt_cur.rdData = cmp_bit(cur_ff.wakeFlag, WAKE_BIT);
      endcase
    end
    // register writes
    if (regWr)
    begin
      unique case (regAddr)
        CTRL0_OFS:
        begin
          // a request may only be withdrawn once it has been acknowledged
          if (regWrData[INIT_REQUEST_BIT] | initAck)
            nxt_cur.init_request = regWrData[INIT_REQUEST_BIT]; // RL21
          if (regWrData[SLEEP_REQUEST_BIT] | sleepAck)
            nxt_cur.sleep_request = regWrData[SLEEP_REQUEST_BIT]; // RL15
          nxt_cur.wakeup_enable = regWrData[WAKEUP_ENABLE_BIT];
          nxt_cur.stop_in_wait = regWrData[STOP_IN_WAIT_BIT];
        end
        CTRL1_OFS:
        begin
          // enable is written once so a stray write cannot switch the node off
          if (!cur_ff.enWritten)
          begin
            nxt_cur.enable = regWrData[ENABLE_BIT];
            nxt_cur.enWritten = 1'h1;
          end
          // mode selection is configuration, locked outside init
          if (initAck)
          begin
            nxt_cur.listen = regWrData[LISTEN_BIT]; // RL19
            nxt_cur.loopback = regWrData[LOOP_BIT]; // RL19
          end
        end
        RIER_OFS: nxt_cur.wakeup_irq_enable = regWrData[WAKE_BIT];
        RFLG_OFS:
        begin
          if (regWrData[WAKE_BIT])
            nxt_cur.wakeFlag = 1'h0;
        end
      endcase
    end
    // mode sequencer
    if (!cur_ff.enable)
    begin
      nxt_cur.state = ST_OFF; // RL5
    end
    else if (powerDown)
    begin
      nxt_cur.state = ST_PDOWN; // RL7
    end
    else
    begin
      unique case (cur_ff.state)
        ST_OFF:
        begin
          nxt_cur.cnt = 4'h0;
          nxt_cur.state = cur_ff.init_request ? ST_INITSYNC : ST_RESYNC;
        end
        ST_PDOWN:
        begin
          // restart the engine: resynchronise before normal operation
          nxt_cur.recCnt = 4'h0;
          nxt_cur.state = ST_RESYNC; // RL7
        end
        ST_NORMAL:
        begin
          nxt_cur.cnt = 4'h0;
          if (cur_ff.init_request)
            nxt_cur.state = ST_INITSYNC; // RL18
          else if (cur_ff.sleep_request)
            nxt_cur.state = ST_SLPWAIT;
        end
        ST_SLPWAIT:
        begin
          if (cur_ff.init_request)
          begin
            nxt_cur.cnt = 4'h0;
            nxt_cur.state = ST_INITSYNC; // RL18
          end
          else if (!txAllEmpty | rxActive | txActive)
            nxt_cur.cnt = 4'h0; // RL9 RL10
          else if (cur_ff.cnt >= SLEEP_SYNC_CYCLES - 4'h1)
          begin
            nxt_cur.state = ST_SLEEP; // RL10
            nxt_cur.wupeHeld = cur_ff.wakeup_enable; // RL14
          end
          else
            nxt_cur.cnt = cur_ff.cnt + 4'h1; // RL10
        end
        ST_SLEEP:
        begin
          nxt_cur.recCnt = 4'h0;
          if (cur_ff.init_request)
          begin
            nxt_cur.cnt = 4'h0;
            nxt_cur.state = ST_INITSYNC;
          end
          else if (!cur_ff.sleep_request)
            nxt_cur.state = ST_RESYNC; // RL15
          else if (cur_ff.wupeHeld & !busRxPin)
          begin
            // bus activity wakes us; the waking frame itself is lost
            nxt_cur.sleep_request = 1'h0; // RL15
            nxt_cur.wakeFlag = 1'h1;
            nxt_cur.state = ST_RESYNC; // RL16
          end
        end
        ST_INITSYNC:
        begin
          if (cur_ff.cnt >= INIT_SYNC_CYCLES - 4'h1)
          begin
            nxt_cur.state = ST_INIT; // RL20
            // control, flag and enable bits back to defaults
            nxt_cur.sleep_request = CTRL_RST; // RL19
            nxt_cur.wakeup_enable = CTRL_RST; // RL19
            nxt_cur.wakeup_irq_enable = CTRL_RST; // RL19
            nxt_cur.wakeFlag = CTRL_RST; // RL19
          end
          else
            nxt_cur.cnt = cur_ff.cnt + 4'h1; // RL20
        end
        ST_INIT:
        begin
          if (!cur_ff.init_request)
            nxt_cur.state = ST_NORMAL; // RL22
        end
        ST_RESYNC:
        begin
          // count consecutive recessive bits; any dominant bit restarts
          if (cur_ff.init_request)
          begin
            nxt_cur.cnt = 4'h0;
            nxt_cur.state = ST_INITSYNC;
          end
          else if (bitTick)
          begin
            if (!busRxPin)
              nxt_cur.recCnt = 4'h0; // RL16
            else if (cur_ff.recCnt >= RESYNC_BITS - 4'h1)
            begin
              nxt_cur.recCnt = 4'h0;
              nxt_cur.wakePulse = 1'h1; // RL17
              nxt_cur.state = ST_NORMAL; // RL16
            end
            else
              nxt_cur.recCnt = cur_ff.recCnt + 4'h1; // RL16
          end
        end
      endcase
    end
    // a wake event in the clearing cycle wins over the software clear
    if (cur_ff.state == ST_SLEEP && cur_ff.wupeHeld && !busRxPin && cur_ff.enable
        && !powerDown && cur_ff.sleep_request && !cur_ff.init_request)
      nxt_cur.wakeFlag = 1'h1;
  end

  // state register
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      cur_ff <= '{state: ST_OFF, init_request: INIT_REQUEST_RST, sleep_request: CTRL_RST, wakeup_enable: CTRL_RST,
                  stop_in_wait: CTRL_RST, enable: CTRL_RST, enWritten: CTRL_RST,
                  listen: CTRL_RST, loopback: CTRL_RST, wakeup_irq_enable: CTRL_RST,
                  wakeFlag: CTRL_RST, wupeHeld: CTRL_RST, cnt: 4'h0, recCnt: 4'h0,
                  wakePulse: CTRL_RST, rdData: 8'h00};
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  // outputs towards pins and the protocol engine
  always_comb
  begin
    regRdData = cur_ff.rdData;
    // only normal and draining-to-sleep states may put dominant bits on the wire
    if ((cur_ff.state == ST_NORMAL || cur_ff.state == ST_SLPWAIT) &&
        !cur_ff.listen && !cur_ff.loopback)
      busTxPin = macTxBit;
    else
      busTxPin = 1'h1; // RL1 RL3 RL12 RL18
    if (cur_ff.loopback)
      macRxBit = macTxBit; // RL3
    else if (cur_ff.listen)
      macRxBit = busRxPin & macTxBit; // RL2
    else if (cur_ff.state == ST_SLEEP && !cur_ff.wupeHeld)
      macRxBit = 1'h1; // RL14
    else
      macRxBit = busRxPin;
    txStartAllow = (cur_ff.state == ST_NORMAL) & !cur_ff.listen & !cur_ff.sleep_request; // RL1
    ignoreAckSlot = cur_ff.loopback; // RL4
    selfRxAllow = cur_ff.loopback; // RL4
    coreClkEn = (cur_ff.state == ST_NORMAL) | (cur_ff.state == ST_SLPWAIT) |
                (cur_ff.state == ST_RESYNC); // RL5 RL12
    regClkEn = cur_ff.enable & (cur_ff.state != ST_PDOWN); // RL5 RL12
    fgMoveAllow = coreClkEn; // RL13
    abortAllow = coreClkEn; // RL13
    busOffCountEn = coreClkEn; // RL12 RL17
    engineAbort = (cur_ff.state == ST_INITSYNC) | (cur_ff.state == ST_PDOWN); // RL18
    initRegReset = initAck; // RL19
    configUnlock = initAck & cur_ff.init_request; // RL19
    wakeRelease = cur_ff.wakePulse; // RL17
    wakeupIrq = cur_ff.wakeFlag & cur_ff.wakeup_irq_enable; // RL6
  end

  // checks
  sequence initReqSeen;
    (cur_ff.state == ST_NORMAL) && cur_ff.init_request && !powerDown && cur_ff.enable;
  endsequence
  sequence initSyncRun;
    (cur_ff.state == ST_INITSYNC) [*5];
  endsequence

  init_sync_a: assert property (@(posedge clock) disable iff (reset) // RL20
    initReqSeen ##1 initSyncRun |=> initAck || powerDown || !cur_ff.enable)
    else $error("init acknowledge late");
  init_tx_a: assert property (@(posedge clock) disable iff (reset) // RL18
    (cur_ff.state == ST_INITSYNC || initAck) |-> busTxPin)
    else $error("tx pin driven in init");
  init_hold_a: assert property (@(posedge clock) disable iff (reset) // RL21
    $fell(cur_ff.init_request) |-> $past(initAck))
    else $error("init request cleared early");
  slp_hold_a: assert property (@(posedge clock) disable iff (reset) // RL15
    $fell(cur_ff.sleep_request) |-> $past(sleepAck) || $past(cur_ff.state == ST_INITSYNC))
    else $error("sleep request cleared early");
  slp_drain_a: assert property (@(posedge clock) disable iff (reset) // RL9
    $rose(sleepAck) |-> $past(txAllEmpty) && $past(!rxActive))
    else $error("sleep entered while busy");
  listen_tx_a: assert property (@(posedge clock) disable iff (reset) // RL1
    cur_ff.listen |-> busTxPin && !txStartAllow)
    else $error("listen-only drove the bus");
  loop_path_a: assert property (@(posedge clock) disable iff (reset) // RL3
    cur_ff.loopback |-> busTxPin && (macRxBit == macTxBit))
    else $error("loopback path broken");
  wake_irq_a: assert property (@(posedge clock) disable iff (reset) // RL6
    $rose(wakeupIrq) |-> cur_ff.wakeup_irq_enable && $past(sleepAck) && $past(cur_ff.wupeHeld)
                         || $past(wakeupIrq == 1'h0) && $rose(cur_ff.wakeup_irq_enable))
    else $error("wake interrupt without sleep");
  sleep_clk_a: assert property (@(posedge clock) disable iff (reset) // RL12
    sleepAck |-> !coreClkEn && regClkEn && busTxPin && !fgMoveAllow)
    else $error("clocks running in sleep");
  off_clk_a: assert property (@(posedge clock) disable iff (reset) // RL5
    !cur_ff.enable |-> !regClkEn ##1 !coreClkEn)
    else $error("clocks running while disabled");
  resync_a: assert property (@(posedge clock) disable iff (reset) // RL16
    $rose(cur_ff.wakePulse) |-> $past(cur_ff.state == ST_RESYNC) && $past(busRxPin))
    else $error("woke without recessive run");

endmodule : cmp_mode_ctrl
`default_nettype wire

// ---- rtl/cmp_pkg.sv ----
// package for the can mode and power controller: register offsets, field positions,
// reset values, state codes and synchronisation counts.
// assumes one bus clock; the can clock domain is folded into it.
package cmp_pkg;
  // register offsets on the plain register port
  localparam logic [1:0] CTRL0_OFS = 2'h0; // control_reg_0
  localparam logic [1:0] CTRL1_OFS = 2'h1; // mode and status
  localparam logic [1:0] RIER_OFS = 2'h2; // rx_irq_enable_reg
  localparam logic [1:0] RFLG_OFS = 2'h3; // rx_flag_reg
  // control_reg_0 fields
  localparam int INIT_REQUEST_BIT = 0;
  localparam int SLEEP_REQUEST_BIT = 1;
  localparam int WAKEUP_ENABLE_BIT = 2;
  localparam int STOP_IN_WAIT_BIT = 5;
  // mode and status fields
  localparam int INIT_ACKNOWLEDGE_BIT = 0;
  localparam int SLEEP_ACKNOWLEDGE_BIT = 1;
  localparam int LISTEN_BIT = 4;
  localparam int LOOP_BIT = 5;
  localparam int ENABLE_BIT = 7;
  // wake-up enable and flag share bit 7 of their registers
  localparam int WAKE_BIT = 7;
  // reset values
  localparam logic INIT_REQUEST_RST = 1'h1;
  localparam logic CTRL_RST = 1'h0;
  // two bus clocks plus three can clocks, both counted on the one clock here
  localparam int INIT_SYNC_BUS = 2;
  localparam int INIT_SYNC_CAN = 3;
  localparam logic [3:0] INIT_SYNC_CYCLES = 4'(INIT_SYNC_BUS + INIT_SYNC_CAN);
  localparam logic [3:0] SLEEP_SYNC_CYCLES = 4'h2; // fixed sleep entry delay
  localparam logic [3:0] RESYNC_BITS = 4'hb; // 11 recessive bits
  // operating states
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_NORMAL = 3'b001,
    ST_SLPWAIT = 3'b010,
    ST_SLEEP = 3'b011,
    ST_INITSYNC = 3'b100,
    ST_INIT = 3'b101,
    ST_RESYNC = 3'b110,
    ST_PDOWN = 3'b111
  } cmp_state_t;
endpackage : cmp_pkg

// ---- verification/cmp_bus_node.sv ----
// far side of the controller: the shared bus with one other node behind a transceiver.
// assumes the pins are logic levels with 1 recessive, as the controller sees them.
`timescale 1ns/100ps
`default_nettype none
module cmp_bus_node
(
  input wire logic busTxPin, // level our controller drives, 1 recessive
  input wire logic domReq, // the other node pulls the bus dominant
  output logic busRxPin // level seen back on the receive pin
);
  // wired-and bus: any dominant driver wins, idle floats recessive
  // the other node only goes dominant when the bench commands it, never on its own
  assign busRxPin = busTxPin & ~domReq;
endmodule : cmp_bus_node
`default_nettype wire

// ---- verification/cmp_mode_ctrl_tb.sv ----
// self-checking bench for the mode and power controller, register port driven directly.
// assumes the design answers reads one cycle late and sits on a wired-and bus node.
`timescale 1ns/100ps
`default_nettype none
module cmp_mode_ctrl_tb
  import cmp_pkg::*;
;
  logic clock = 1'b0; // 50 MHz
  logic reset = 1'b1; // async, active high
  logic [1:0] regAddr = 2'h0; // register offset
  logic [7:0] regWrData = 8'h00; // write data
  logic regWr = 1'b0; // write strobe
  logic regRd = 1'b0; // read strobe
  logic [7:0] regRdData; // read data
  logic cpuWait = 1'b0; // cpu modes
  logic cpuStopLight = 1'b0;
  logic cpuStopDeep = 1'b0;
  logic busRxPin, busTxPin, macRxBit; // bus and engine lines
  logic macTxBit = 1'b1; // engine bit, recessive at rest
  logic bitTick = 1'b0; // bit time pulse
  logic txActive = 1'b0; // engine activity
  logic rxActive = 1'b0;
  logic [2:0] txBufEmptyFlag = 3'h7; // all buffers empty
  logic domReq = 1'b0; // other node drives dominant
  logic txStartAllow, ignoreAckSlot, selfRxAllow, coreClkEn, regClkEn, fgMoveAllow;
  logic abortAllow, busOffCountEn, engineAbort, initRegReset, configUnlock;
  logic wakeRelease, wakeupIrq; // wake outputs
  int err_count = 0; // mismatches
  int num_checks = 0; // comparisons made
  int relCnt = 0; // wake release pulses seen
  int cycCnt = 0; // hang guard
  cmp_mode_ctrl cmp_mode_ctrl_inst (.clock(clock), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .cpuWait(cpuWait), .cpuStopLight(cpuStopLight), .cpuStopDeep(cpuStopDeep),
    .busRxPin(busRxPin), .busTxPin(busTxPin), .macTxBit(macTxBit), .macRxBit(macRxBit),
    .bitTick(bitTick), .txActive(txActive), .rxActive(rxActive),
    .txBufEmptyFlag(txBufEmptyFlag), .txStartAllow(txStartAllow),
    .ignoreAckSlot(ignoreAckSlot), .selfRxAllow(selfRxAllow), .coreClkEn(coreClkEn),
    .regClkEn(regClkEn), .fgMoveAllow(fgMoveAllow), .abortAllow(abortAllow),
    .busOffCountEn(busOffCountEn), .engineAbort(engineAbort), .initRegReset(initRegReset),
    .configUnlock(configUnlock), .wakeRelease(wakeRelease), .wakeupIrq(wakeupIrq));
  cmp_bus_node cmp_bus_node_inst (.busTxPin(busTxPin), .domReq(domReq), .busRxPin(busRxPin));
  // free-running clock, 20 ns period
  initial
  begin
    forever #10 clock = ~clock;
  end
  // count release pulses on the falling edge, where the registered pulse has settled
  always @(negedge clock)
  begin
    if (wakeRelease === 1'b1)
      relCnt++;
  end
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clock)
  begin
    cycCnt++;
    if (cycCnt == 4000)
    begin
      err_count++;
      end_of_test();
    end
  end
  // verdict and end of run
  task automatic end_of_test();
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // byte compare, case equality so unknowns fail
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t byte got %h want %h", $time, got, exp);
    end
  endtask : chk8
  // single-bit compare
  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t bit got %b want %b", $time, got, exp);
    end
  endtask : chk1
  // wait n edges, then step past them so outputs are settled
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // one-cycle write strobe
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask : wr
  // one-cycle read strobe; data only stands in the following cycle
  task automatic rdChk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    chk8(regRdData, exp);
  endtask : rdChk
  // n bit ticks, one every other clock
  task automatic bits(input int n);
    repeat (n)
    begin
      @(posedge clock);
      bitTick <= 1'b1;
      @(posedge clock);
      bitTick <= 1'b0;
    end
  endtask : bits
  // enter init (or enable from off), wait for the ack, set mode, leave init
  task automatic remode(input logic fromOff, input logic [7:0] prev, input logic [7:0] mode);
    if (fromOff)
      wr(CTRL1_OFS, 8'h80);
    else
    begin
      wr(CTRL0_OFS, 8'h01);
      wr(CTRL0_OFS, 8'h00); // clearing before the ack is refused
      rdChk(CTRL0_OFS, 8'h01);
    end
    rdChk(CTRL1_OFS, prev);
    tick(8);
    rdChk(CTRL1_OFS, prev | 8'h01);
    chk1(initRegReset, 1'b1);
    chk1(configUnlock, 1'b1);
    chk1(regClkEn, 1'b1);
    chk1(busTxPin, 1'b1);
    wr(CTRL1_OFS, mode);
    wr(CTRL0_OFS, 8'h00);
    rdChk(CTRL1_OFS, mode);
  endtask : remode
  // main sequence
  initial
  begin
    macTxBit = 1'b0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    tick(1);
    chk1(coreClkEn, 1'b0);
    chk1(regClkEn, 1'b0);
    chk1(busTxPin, 1'b1);
    // listen-only: dominant request stays inside
    remode(1'b1, 8'h80, 8'h90);
    chk1(busTxPin, 1'b1);
    chk1(txStartAllow, 1'b0);
    chk1(macRxBit, 1'b0);
    // loopback: receive pin ignored, own bit returned
    remode(1'b0, 8'h90, 8'ha0);
    @(posedge clock);
    domReq <= 1'b1;
    macTxBit <= 1'b1;
    tick(1);
    chk1(macRxBit, 1'b1);
    chk1(busTxPin, 1'b1);
    chk1(ignoreAckSlot, 1'b1);
    chk1(selfRxAllow, 1'b1);
    @(posedge clock);
    macTxBit <= 1'b0;
    domReq <= 1'b0;
    tick(1);
    chk1(macRxBit, 1'b0);
    // back to normal: pin follows the engine
    remode(1'b0, 8'ha0, 8'h80);
    chk1(busTxPin, 1'b0);
    chk1(txStartAllow, 1'b1);
    chk1(coreClkEn, 1'b1);
    // sleep held off by a pending buffer, then by reception
    @(posedge clock);
    macTxBit <= 1'b1;
    txActive <= 1'b1;
    txBufEmptyFlag <= 3'h5;
    wr(CTRL0_OFS, 8'h06);
    tick(8);
    rdChk(CTRL1_OFS, 8'h80);
    wr(CTRL0_OFS, 8'h04);
    rdChk(CTRL0_OFS, 8'h06);
    txActive <= 1'b0;
    rxActive <= 1'b1;
    txBufEmptyFlag <= 3'h7;
    tick(8);
    rdChk(CTRL1_OFS, 8'h80);
    @(posedge clock);
    rxActive <= 1'b0;
    macTxBit <= 1'b0;
    tick(6);
    rdChk(CTRL1_OFS, 8'h82);
    chk1(coreClkEn, 1'b0);
    chk1(regClkEn, 1'b1);
    chk1(busOffCountEn, 1'b0);
    chk1(busTxPin, 1'b1);
    chk1(fgMoveAllow, 1'b0);
    chk1(abortAllow, 1'b0);
    // wake on bus activity, interrupt, then 11 recessive bits
    wr(RIER_OFS, 8'h80);
    domReq <= 1'b1;
    tick(3);
    @(posedge clock);
    domReq <= 1'b0;
    tick(2);
    chk1(wakeupIrq, 1'b1);
    rdChk(RFLG_OFS, 8'h80);
    rdChk(CTRL0_OFS, 8'h04);
    bits(10);
    tick(2);
    chk8(8'(relCnt), 8'h00);
    bits(1);
    tick(2);
    chk8(8'(relCnt), 8'h01);
    wr(RFLG_OFS, 8'h80);
    tick(1);
    chk1(wakeupIrq, 1'b0);
    // sleep without wake enable: locked until the cpu clears the request
    wr(CTRL0_OFS, 8'h02);
    tick(6);
    rdChk(CTRL1_OFS, 8'h82);
    domReq <= 1'b1;
    tick(1);
    chk1(macRxBit, 1'b1);
    @(posedge clock);
    domReq <= 1'b0;
    rdChk(CTRL1_OFS, 8'h82);
    wr(CTRL0_OFS, 8'h00);
    tick(2);
    rdChk(CTRL1_OFS, 8'h80);
    bits(11);
    // wait mode: only with stop_in_wait does it power down
    @(posedge clock);
    cpuWait <= 1'b1;
    tick(3);
    chk1(regClkEn, 1'b1);
    wr(CTRL0_OFS, 8'h20);
    tick(2);
    chk1(regClkEn, 1'b0);
    chk1(coreClkEn, 1'b0);
    chk1(busTxPin, 1'b1);
    chk1(engineAbort, 1'b1);
    @(posedge clock);
    cpuWait <= 1'b0;
    tick(2);
    bits(11);
    tick(2);
    chk1(coreClkEn, 1'b1);
    // stop modes power down with sleep bits clear
    cpuStopDeep <= 1'b1;
    tick(2);
    chk1(regClkEn, 1'b0);
    @(posedge clock);
    cpuStopDeep <= 1'b0;
    cpuStopLight <= 1'b1;
    tick(2);
    chk1(regClkEn, 1'b0);
    end_of_test();
  end
endmodule : cmp_mode_ctrl_tb
`default_nettype wire
